// [rtl/mic_consts.svh]
/*
 * timing counts, reset values and fixed positions of the maskable
 * interrupt control block; included by the package and the design.
 */
`ifndef MIC_CONSTS_SVH
`define MIC_CONSTS_SVH
`define MIC_SRC_N 20
`define MIC_VEC_W 5
`define MIC_EDGE_WIN_CYC 7'h40
`define MIC_CNT_W 7
`define MIC_EXT_SRC 5'h0
`define MIC_MASK_RST 1'b1
`define MIC_EDGE_RST 1'b0
`define MIC_PUSH_FIRST 4'h0
`define MIC_PUSH_LAST 4'h8
`endif

// [rtl/mic_pkg.sv]
/*
 * types of the maskable interrupt control block.
 * assumes mic_consts.svh is on the include path.
 */
`include "mic_consts.svh"
`default_nettype none
package mic_pkg;
  // sequencer states, gray along idle, push, vector
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_PUSH = 2'h1,
    SEQ_VECT = 2'h3,
    SEQ_POP = 2'h2
  } seq_t;
  // register stacked or restored, numbered in push order
  typedef enum logic [3:0] {
    SEL_PCL = 4'h0, SEL_PCH = 4'h1, SEL_IYL = 4'h2, SEL_IYH = 4'h3,
    SEL_IXL = 4'h4, SEL_IXH = 4'h5, SEL_ACCA = 4'h6, SEL_ACCB = 4'h7,
    SEL_FLAGS = 4'h8
  } reg_sel_t;
  // strobes from the instruction sequencer
  typedef struct packed {
    logic instr_done;
    logic set_mask_instr;
    logic clear_mask_instr;
    logic return_from_int_instr;
    logic stack_ack;
    logic restored_mask;
  } cpu_ctl_t;
  // stack request towards the instruction sequencer
  typedef struct packed {
    logic req;
    logic pop;
    reg_sel_t sel;
  } stack_port_t;
  // whole state of the controller
  typedef struct packed {
    seq_t seq;
    reg_sel_t sel;
    logic mask;
    logic clr_pend;
    logic sync1;
    logic sync2;
    logic prev;
    logic ext_latch;
    logic edge_sel;
    logic sel_written;
    logic [`MIC_CNT_W-1:0] win_cnt;
    logic vec_valid;
    logic [`MIC_VEC_W-1:0] vec_id;
  } state_t;
endpackage : mic_pkg
`default_nettype wire

// [rtl/mic_prio.sv]
/*
 * fixed priority resolver, lowest index wins, one index promotable.
 * assumes purely combinational use from the controller.
 */
`default_nettype none
module mic_prio #(
  parameter int N = 20,
  parameter int W = 5
) (
  input wire logic [N-1:0] req,
  input wire logic promote_en,
  input wire logic [W-1:0] promote_idx,
  output logic any,
  output logic [W-1:0] idx
);
  // scan from the top so the lowest pending index is written last and kept
  always_comb begin
    any = |req;
    idx = W'(N);
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = W'(i);
      end
    end
    if (promote_en && (int'(promote_idx) < N) && req[promote_idx]) begin
      idx = promote_idx;
    end
  end
endmodule : mic_prio
`default_nettype wire

// [rtl/maskable_interrupt_control.sv]
/*
 * maskable interrupt control: global mask with delayed clear, fixed
 * priority with promotion, stacking order, external pin sensing.
 * assumes the sequencer gives one-cycle strobes on clk and answers
 * stack requests with stack_ack; source flags arrive on clk.
 */
`include "mic_consts.svh"
`default_nettype none
module maskable_interrupt_control #(
  parameter int NUM_SRC = `MIC_SRC_N,
  parameter int VEC_W = `MIC_VEC_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire mic_pkg::cpu_ctl_t cpu,
  input wire logic [NUM_SRC-1:0] src_flag,
  input wire logic [NUM_SRC-1:0] src_enable,
  input wire logic ext_pin_n,
  input wire logic expanded_mode,
  input wire logic edge_sel_wr,
  input wire logic edge_sel_wdata,
  input wire logic promote_en,
  input wire logic [VEC_W-1:0] promote_idx,
  output mic_pkg::stack_port_t stack,
  output logic vector_valid,
  output logic [VEC_W-1:0] vector_id,
  output logic int_take,
  output logic int_pending,
  output logic mask_bit,
  output logic ext_pin_edge_select,
  output logic hsio_external
);
  import mic_pkg::*;

  localparam state_t RST = '{
    seq: SEQ_IDLE, sel: SEL_PCL, mask: `MIC_MASK_RST, clr_pend: 1'b0,
    sync1: 1'b1, sync2: 1'b1, prev: 1'b1, ext_latch: 1'b0,
    edge_sel: `MIC_EDGE_RST, sel_written: 1'b0, win_cnt: '0,
    vec_valid: 1'b0, vec_id: '0};

  state_t q;
  state_t d;
  logic [NUM_SRC-1:0] req;
  logic ext_req;
  logic fall;
  logic any;
  logic [VEC_W-1:0] win_idx;
  logic mask_eff;

  ////////////////////////////////////////////////////////////////////////
  // request gathering

  // falling edge seen only between the second sync stage and its copy
  assign fall = q.prev & ~q.sync2;
  // edge mode uses the latch, level mode the synchronised low level
  assign ext_req = q.edge_sel ? q.ext_latch : ~q.sync2;

  // local enables on peripheral flags; pin and handshake on index 0
  always_comb begin
    req = src_flag & src_enable;
    req[`MIC_EXT_SRC] = ext_req
      | (src_flag[`MIC_EXT_SRC] & src_enable[`MIC_EXT_SRC]
         & ~expanded_mode);
  end

  mic_prio #(
    .N(NUM_SRC),
    .W(VEC_W)
  ) prio (
    .req(req),
    .promote_en(promote_en),
    .promote_idx(promote_idx),
    .any(any),
    .idx(win_idx)
  );

  // a set strobe masks in its own cycle
  assign mask_eff = q.mask | cpu.set_mask_instr;
  assign int_take = cpu.instr_done & ~mask_eff & any
    & (q.seq == SEQ_IDLE) & ~cpu.return_from_int_instr;

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    d.vec_valid = 1'b0;
    // pin synchroniser and edge history
    d.sync1 = ext_pin_n;
    d.sync2 = q.sync1;
    d.prev = q.sync2;
    // edge latch: a new edge wins over the clear by the vector fetch
    if (q.seq == SEQ_VECT && any && win_idx == `MIC_EXT_SRC) begin
      d.ext_latch = 1'b0;
    end
    if (q.edge_sel && fall) begin
      d.ext_latch = 1'b1;
    end
    if (!q.edge_sel) begin
      d.ext_latch = 1'b0;
    end
    // write-once window for the edge select
    if (q.win_cnt < `MIC_EDGE_WIN_CYC) begin
      d.win_cnt = q.win_cnt + `MIC_CNT_W'(1);
    end
    if (edge_sel_wr && !q.sel_written
        && q.win_cnt < `MIC_EDGE_WIN_CYC) begin
      d.edge_sel = edge_sel_wdata;
      d.sel_written = 1'b1;
    end
    // delayed clear expires one cycle after it was armed
    if (q.clr_pend) begin
      d.mask = 1'b0;
      d.clr_pend = 1'b0;
    end
    if (cpu.clear_mask_instr) begin
      d.clr_pend = 1'b1;
    end
    if (cpu.set_mask_instr) begin
      d.mask = 1'b1;
      d.clr_pend = 1'b0;
    end
    // stacking sequencer
    case (q.seq)
      SEQ_IDLE: begin
        if (int_take) begin
          d.seq = SEQ_PUSH;
          d.sel = reg_sel_t'(`MIC_PUSH_FIRST);
        end else if (cpu.return_from_int_instr) begin
          d.seq = SEQ_POP;
          d.sel = reg_sel_t'(`MIC_PUSH_LAST);
        end
      end
      SEQ_PUSH: begin
        if (cpu.stack_ack) begin
          if (q.sel == reg_sel_t'(`MIC_PUSH_LAST)) begin
            d.mask = 1'b1;
            d.clr_pend = 1'b0;
            d.seq = SEQ_VECT;
          end else begin
            d.sel = reg_sel_t'(q.sel + 4'h1);
          end
        end
      end
      SEQ_VECT: begin
        // resolve at fetch time, not at stacking start
        d.vec_valid = 1'b1;
        d.vec_id = any ? win_idx : VEC_W'(NUM_SRC);
        d.seq = SEQ_IDLE;
      end
      SEQ_POP: begin
        if (cpu.stack_ack) begin
          if (q.sel == SEL_FLAGS) begin
            // restored flags: clear goes through the delay
            if (cpu.restored_mask) begin
              d.mask = 1'b1;
              d.clr_pend = 1'b0;
            end else begin
              d.clr_pend = 1'b1;
            end
          end
          if (q.sel == reg_sel_t'(`MIC_PUSH_FIRST)) begin
            d.seq = SEQ_IDLE;
          end else begin
            d.sel = reg_sel_t'(q.sel - 4'h1);
          end
        end
      end
      default: begin
        d.seq = SEQ_IDLE;
      end
    endcase
  end

  // state register, synchronous reset
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign stack.req = (q.seq == SEQ_PUSH) || (q.seq == SEQ_POP);
  assign stack.pop = (q.seq == SEQ_POP);
  assign stack.sel = q.sel;
  assign vector_valid = q.vec_valid;
  assign vector_id = q.vec_id;
  assign int_pending = any;
  assign mask_bit = q.mask;
  assign ext_pin_edge_select = q.edge_sel;
  assign hsio_external = expanded_mode;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence push_ack_flags_s;
    stack.req && !stack.pop && stack.sel == SEL_FLAGS && cpu.stack_ack;
  endsequence
  sequence vector_out_s;
    ##1 mask_bit ##1 vector_valid;
  endsequence

  always @(posedge clk) begin
    if (!reset && $past(reset)) begin
      mask_reset_a: assert (mask_bit && !ext_pin_edge_select)
        else $error("mask or edge select wrong after reset");
    end
  end

  take_needs_clear_a: assert property (
    int_take |-> !mask_bit && !cpu.set_mask_instr && int_pending)
    else $error("interrupt taken while masked");

  set_blocks_a: assert property (
    cpu.set_mask_instr && !cpu.clear_mask_instr |=> mask_bit)
    else $error("set strobe did not mask");

  clear_delay_a: assert property (
    cpu.clear_mask_instr && !cpu.set_mask_instr && mask_bit
    && stack.req == 1'b0 ##1 !cpu.set_mask_instr
    |-> mask_bit ##1 !mask_bit)
    else $error("mask clear not delayed by one cycle");

  push_start_a: assert property (
    int_take |=> stack.req && !stack.pop && stack.sel == SEL_PCL)
    else $error("stacking does not begin with pc low");

  flags_then_vector_a: assert property (
    push_ack_flags_s |-> vector_out_s)
    else $error("mask or vector missing after flags push");

  pop_first_a: assert property (
    q.seq == SEQ_IDLE && cpu.return_from_int_instr && !int_take
    |=> stack.pop && stack.sel == SEL_FLAGS)
    else $error("return does not restore flags first");

  edge_latch_a: assert property (
    ext_pin_edge_select && q.prev && !q.sync2 |=> q.ext_latch)
    else $error("falling edge not latched");

  held_low_a: assert property (
    ext_pin_edge_select && !q.sync2 && !q.prev && !q.ext_latch
    && !(edge_sel_wr) |=> !q.ext_latch)
    else $error("edge registered while pin held low");

  edge_window_a: assert property (
    q.win_cnt >= `MIC_EDGE_WIN_CYC || q.sel_written
    |=> $stable(ext_pin_edge_select))
    else $error("edge select changed outside write window");

  shared_vector_a: assert property (
    vector_valid && !$past(any) |-> vector_id == VEC_W'(NUM_SRC))
    else $error("spurious vector code wrong");
endmodule : maskable_interrupt_control
`default_nettype wire

// [bench/cpu_seq_model.sv]
/*
 * stack side of the instruction sequencer: acks each stack byte.
 * assumes the controller's clk and reset; moves on the falling edge.
 */
`default_nettype none
module cpu_seq_model (
  input wire logic clk,
  input wire logic reset,
  input wire mic_pkg::stack_port_t stack,
  input wire logic [2:0] delay,
  input wire logic restore_val,
  output logic stack_ack,
  output logic restored_mask
);
  import mic_pkg::*;
  logic [2:0] wait_q;
  initial begin
    stack_ack = 1'b0;
    wait_q = 3'h0;
  end
  // one ack per byte after delay idle cycles, dropped after one cycle
  always @(negedge clk) begin
    if (reset || stack_ack || !stack.req) begin
      stack_ack <= 1'b0;
      wait_q <= 3'h0;
    end else if (wait_q == delay) begin
      stack_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 3'h1;
    end
  end
  // popped mask bit is only meaningful with the ack
  assign restored_mask = stack_ack ? restore_val : ~restore_val;
endmodule : cpu_seq_model
`default_nettype wire

// [bench/maskable_interrupt_control_bench.sv]
/*
 * self-checking bench of the maskable interrupt controller.
 * assumes the sequencer model; inputs move on the falling edge.
 */
`default_nettype none
module maskable_interrupt_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import mic_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  cpu_ctl_t strb = 6'h00;
  cpu_ctl_t cpu;
  logic [19:0] flag = 20'h0_0000;
  logic [19:0] en = 20'h0_0000;
  logic pin_n = 1'b1;
  logic exp_m = 1'b0;
  logic sel_wr = 1'b0;
  logic sel_wd = 1'b0;
  logic pro_en = 1'b0;
  logic rval = 1'b0;
  logic [4:0] pro_idx = 5'h00;
  logic [2:0] dly = 3'h1;
  stack_port_t stack;
  logic ack, rmask, vvalid, take, pend, mask, esel, hsio, tk;
  logic [4:0] vid;
  logic [31:0] seed = 32'h0000_1057;
  int failures = 0;
  int samples_checked = 0;
  logic [3:0] order[$];

  maskable_interrupt_control maskable_interrupt_control_i (
    .clk(clk), .reset(reset), .cpu(cpu), .src_flag(flag),
    .src_enable(en), .ext_pin_n(pin_n), .expanded_mode(exp_m),
    .edge_sel_wr(sel_wr), .edge_sel_wdata(sel_wd), .promote_en(pro_en),
    .promote_idx(pro_idx), .stack(stack), .vector_valid(vvalid),
    .vector_id(vid), .int_take(take), .int_pending(pend),
    .mask_bit(mask), .ext_pin_edge_select(esel), .hsio_external(hsio));
  cpu_seq_model cpu_seq_model_i (
    .clk(clk), .reset(reset), .stack(stack), .delay(dly),
    .restore_val(rval), .stack_ack(ack), .restored_mask(rmask));

  ////////////////////////////////////////////////////////////////////////
  // clock, strobe merge and stack byte log
  always #50 clk = ~clk;
  always_comb begin
    cpu = strb;
    cpu.stack_ack = ack;
    cpu.restored_mask = rmask;
  end
  always @(posedge clk) if (stack.req && ack) order.push_back(stack.sel);

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // expected vector from the gated level requests
  function automatic logic [4:0] exp_vec();
    logic [19:0] g;
    g = flag & en;
    g[0] = (g[0] & ~exp_m) | ~pin_n;
    if (pro_en && g[pro_idx]) return pro_idx;
    for (int i = 0; i < 20; i++) if (g[i]) return i[4:0];
    return 5'h14;
  endfunction : exp_vec
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    samples_checked++;
    if (got !== want) begin
      failures++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // one-cycle strobe; reports int_take seen in that cycle
  task automatic strobe(input logic d, s, c, r);
    strb = {d, s, c, r, 2'b00};
    #1 tk = take;
    tick(1);
    strb = 6'h00;
  endtask : strobe
  task automatic clear_mask();
    strobe(1'b0, 1'b0, 1'b1, 1'b0);
    tick(1);
  endtask : clear_mask
  task automatic do_reset();
    reset = 1'b1;
    tick(20);
    chk(mask, 8'h01);
    chk(esel, 8'h00);
    chk(stack.req, 8'h00);
    reset = 1'b0;
  endtask : do_reset
  task automatic wr_sel(input logic v);
    sel_wd = v;
    sel_wr = 1'b1;
    tick(1);
    sel_wr = 1'b0;
    tick(1);
  endtask : wr_sel
  // take, nine pushes, vector, then return with nine pops
  task automatic service(input logic [4:0] ev, input logic r);
    order.delete();
    strobe(1'b1, 1'b0, 1'b0, 1'b0);
    chk(tk, 8'h01);
    for (int i = 0; i < 300 && vvalid !== 1'b1; i++) @(negedge clk);
    chk(vvalid, 8'h01);
    chk(vid, ev);
    chk(mask, 8'h01);
    chk(8'(order.size()), 8'h09);
    foreach (order[i]) chk(order[i], 8'(i));
    order.delete();
    rval = r;
    strobe(1'b0, 1'b0, 1'b0, 1'b1);
    chk(stack.pop, 8'h01);
    for (int i = 0; i < 300 && stack.req !== 1'b0; i++) @(negedge clk);
    chk(stack.req, 8'h00);
    chk(8'(order.size()), 8'h09);
    foreach (order[i]) chk(order[i], 8'(8 - i));
    tick(2);
    chk(mask, r);
  endtask : service
  task automatic final_report();
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    tick(1);
    do_reset();
    flag = 20'h0_0030;
    en = 20'h0_0020;
    strobe(1'b1, 1'b0, 1'b0, 1'b0);
    chk(tk, 8'h00);
    tick(1);
    // clear strobe, then the following instruction ends one cycle later
    strb = 6'h08;
    tick(1);
    chk(mask, 8'h01);
    strb = 6'h20;
    #1 chk(take, 8'h00);
    tick(1);
    strb = 6'h00;
    chk(mask, 8'h00);
    chk(pend, 8'h01);
    tick(1);
    service(5'h05, 1'b0);
    strobe(1'b1, 1'b1, 1'b0, 1'b0);
    chk(tk, 8'h00);
    chk(mask, 8'h01);
    tick(1);
    clear_mask();
    flag = 20'h0_0000;
    pin_n = 1'b0;
    tick(4);
    chk(pend, 8'h01);
    service(5'h00, 1'b0);
    pin_n = 1'b1;
    tick(4);
    chk(pend, 8'h00);
    for (int n = 0; n < 8; n++) begin
      seed = lfsr_next(seed);
      flag = seed[19:0] | 20'h0_8000;
      seed = lfsr_next(seed);
      en = seed[19:0] | 20'h0_8000;
      exp_m = seed[20];
      pro_en = seed[21];
      dly = seed[24:22];
      pro_idx = 5'(seed[31:24] % 8'h14);
      tick(4);
      chk(hsio, exp_m);
      service(exp_vec(), seed[25]);
      if (mask === 1'b1) clear_mask();
      flag = 20'h0_0000;
    end
    do_reset();
    tick(70);
    wr_sel(1'b1);
    chk(esel, 8'h00);
    do_reset();
    wr_sel(1'b1);
    chk(esel, 8'h01);
    wr_sel(1'b0);
    chk(esel, 8'h01);
    clear_mask();
    pin_n = 1'b0;
    tick(5);
    chk(pend, 8'h01);
    service(5'h00, 1'b0);
    tick(5);
    chk(pend, 8'h00);
    pin_n = 1'b1;
    tick(3);
    pin_n = 1'b0;
    tick(5);
    chk(pend, 8'h01);
    service(5'h00, 1'b0);
    final_report();
  end
endmodule : maskable_interrupt_control_bench
`default_nettype wire
